//--- csc_pkg.sv
// Shared constants of the clock synthesizer configuration register bank.
// Assumes a single 100 MHz clock domain and a synchronous active high reset.
package csc_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FREQ          = 8'h00;
    localparam logic [7:0] OFS_CLK           = 8'h01;
    localparam logic [7:0] OFS_DIV           = 8'h02;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int         BIT_SW_SELECT     = 7;
    localparam int         BIT_SPREAD_EN     = 6;
    localparam int         BIT_SPREAD_TYPE   = 5;
    localparam int         BIT_TABLE_HI      = 4;
    localparam int         BIT_TABLE_LO      = 3;
    localparam int         BIT_FS_HI         = 2;
    localparam int         BIT_DRIVE_LO      = 4;
    localparam int         BIT_DIV_HI        = 6;

    // ------------------------------------------------------------------
    // Reset values and special codes.
    // ------------------------------------------------------------------
    localparam logic       RST_SW_SELECT     = 1'b0;
    localparam logic       RST_SPREAD_TYPE   = 1'b0;
    localparam logic [1:0] RST_TABLE         = 2'h0;
    localparam logic [3:0] RST_DRIVE         = 4'hF;
    localparam logic [3:0] RST_RUN           = 4'hF;
    localparam logic [6:0] RST_DIV           = 7'h00;
    localparam logic [2:0] FS_UNDECODED      = 3'h7;

    // ------------------------------------------------------------------
    // Serial port constants.
    // ------------------------------------------------------------------
    // Slave address value is arbitrary.
    localparam logic [6:0] DEV_ADDR          = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
    // Edges after reset release at which the pin sampling chain is valid.
    localparam logic [1:0] CAPTURE_EDGE      = 2'h2;

    typedef enum logic [3:0]
    {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_CMD       = 4'h3,
        ST_CMD_ACK   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RDATA_ACK = 4'h8
    } csc_state_type;

endpackage : csc_pkg

//--- csc_bus_sync.sv
// Two-wire line conditioner: synchroniser, clock edges, start and stop.
// Assumes raw line levels that are asynchronous to ref_clk.
`timescale 1ns/10ps
module csc_bus_sync
    import csc_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Raw lines
    input  wire logic sclIn,
    input  wire logic sdaIn,
    // Conditioned events
    output logic      sclRise,
    output logic      sclFall,
    output logic      startSeen,
    output logic      stopSeen,
    output logic      sdaBit
);

    logic [2:0] sclPipe;
    logic [2:0] sdaPipe;

    // ------------------------------------------------------------------
    // Synchroniser; stage 0 feeds only stage 1.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sclPipe <= 3'h7;
            sdaPipe <= 3'h7;
        end
        else
        begin
            sclPipe <= {sclPipe[1:0], sclIn};
            sdaPipe <= {sdaPipe[1:0], sdaIn};
        end
    end

    // ------------------------------------------------------------------
    // Line events.
    // ------------------------------------------------------------------
    assign sdaBit    = sdaPipe[1];
    assign sclRise   = sclPipe[1] & ~sclPipe[2];
    assign sclFall   = ~sclPipe[1] & sclPipe[2];
    assign startSeen = sclPipe[1] & sclPipe[2] & ~sdaPipe[1] & sdaPipe[2];
    assign stopSeen  = sclPipe[1] & sclPipe[2] & sdaPipe[1] & ~sdaPipe[2];

endmodule : csc_bus_sync

//--- csc_regs.sv
// Configuration register bank of a spread spectrum host clock synthesizer.
// Assumes a two-wire host on sclIn/sdaIn with an external pull-up resolving sda.
// Notes on behaviour
// - Software select set: register bits drive selection.
// - Software select clear: pins drive selection.
// - Frequency readback follows the selection in force.
// - Software select is zero after reset.
// - Spread enable captures pin, software may overwrite.
// - Spread type bit, zero down, one center.
// - Two spread table bits reset to zero.
// - Frequency code loads from pins at startup.
// - All-ones code not decoded under software select.
// - Drive strength bits, one high, reset high.
// - Run bits stop outputs immediately, reset running.
// - Seven-bit feedback value, resets to zero.
// - Fine enable picks divider or the frequency selection in force.
// - Serial slave drives data only for ack/data.
`timescale 1ns/10ps
module csc_regs
    import csc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Serial port
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOutEnN,
    // Select pins
    input  wire logic [2:0] freqSelPin,
    input  wire logic       spreadEnPin,
    input  wire logic       fineFreqEnable,
    // Synthesizer controls
    output logic [2:0]      freqSelect,
    output logic            freqSelValid,
    output logic            spreadEnable,
    output logic            spreadType,
    output logic [1:0]      spreadTable,
    output logic            freqFromDivider,
    output logic [3:0]      outDrive,
    output logic [3:0]      outRun,
    output logic [6:0]      feedbackValue
);

    logic          sclRise;
    logic          sclFall;
    logic          startSeen;
    logic          stopSeen;
    logic          sdaBit;
    logic [3:0]    pinMeta;
    logic [3:0]    pinSync;
    logic [1:0]    capCnt;
    logic          capture;
    logic          swSelect;
    logic          spreadEnReg;
    logic          spreadTypeReg;
    logic [1:0]    spreadTableReg;
    logic [2:0]    fsCode;
    logic [3:0]    driveReg;
    logic [3:0]    runReg;
    logic [6:0]    divReg;
    csc_state_type state;
    logic [3:0]    bitCnt;
    logic [7:0]    shiftReg;
    logic [7:0]    pointer;
    logic          masterAck;
    logic          sdaLow;
    logic          regWrite;
    logic [7:0]    wrData;
    logic [7:0]    rdByte;
    logic [7:0]    nextByte;

    csc_bus_sync u_sync
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .sclIn     (sclIn),
        .sdaIn     (sdaIn),
        .sclRise   (sclRise),
        .sclFall   (sclFall),
        .startSeen (startSeen),
        .stopSeen  (stopSeen),
        .sdaBit    (sdaBit)
    );

    // ------------------------------------------------------------------
    // Pin sampling and startup capture.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
        end
        else
        begin
            pinMeta <= {spreadEnPin, freqSelPin};
            pinSync <= pinMeta;
        end
    end

    // Pins are caught only once the two-stage chain holds post-reset samples.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            capCnt <= 2'h0;
        end
        else if (capCnt != 2'h3)
        begin
            capCnt <= capCnt + 2'h1;
        end
    end

    assign capture = (capCnt == CAPTURE_EDGE);

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            swSelect       <= RST_SW_SELECT;
            spreadEnReg    <= 1'b0;
            spreadTypeReg  <= RST_SPREAD_TYPE;
            spreadTableReg <= RST_TABLE;
            fsCode         <= 3'h0;
        end
        else if (regWrite && pointer == OFS_FREQ)
        begin
            swSelect       <= wrData[BIT_SW_SELECT];
            spreadEnReg    <= wrData[BIT_SPREAD_EN];
            spreadTypeReg  <= wrData[BIT_SPREAD_TYPE];
            spreadTableReg <= wrData[BIT_TABLE_HI:BIT_TABLE_LO];
            fsCode         <= wrData[BIT_FS_HI:0];
        end
        else if (capture)
        begin
            spreadEnReg    <= pinSync[3];
            fsCode         <= pinSync[2:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            driveReg <= RST_DRIVE;
            runReg   <= RST_RUN;
        end
        else if (regWrite && pointer == OFS_CLK)
        begin
            driveReg <= wrData[7:BIT_DRIVE_LO];
            runReg   <= wrData[BIT_DRIVE_LO-1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            divReg <= RST_DIV;
        end
        else if (regWrite && pointer == OFS_DIV)
        begin
            divReg <= wrData[BIT_DIV_HI:0];
        end
    end

    // ------------------------------------------------------------------
    // Selection in force.
    // ------------------------------------------------------------------
    // Run bits reach the outputs straight from their flops, so a clear stops a clock with no alignment.
    assign outRun   = runReg;
    assign outDrive = driveReg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            freqSelect      <= 3'h0;
            freqSelValid    <= 1'b0;
            spreadEnable    <= 1'b0;
            spreadType      <= RST_SPREAD_TYPE;
            spreadTable     <= RST_TABLE;
            freqFromDivider <= 1'b0;
            feedbackValue   <= RST_DIV;
        end
        else
        begin
            spreadType      <= spreadTypeReg;
            spreadTable     <= spreadTableReg;
            freqFromDivider <= fineFreqEnable;
            feedbackValue   <= divReg;
            if (swSelect)
            begin
                freqSelect   <= fsCode;
                spreadEnable <= spreadEnReg;
                freqSelValid <= (fsCode != FS_UNDECODED);
            end
            else
            begin
                freqSelect   <= pinSync[2:0];
                spreadEnable <= pinSync[3];
                freqSelValid <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_byte(input logic [7:0] ofs);
        logic [7:0] value;
        value = 8'h00;
        case (ofs)
            OFS_FREQ:
            begin
                if (swSelect)
                    value = {1'b1, spreadEnReg, spreadTypeReg, spreadTableReg, fsCode};
                else
                    value = {1'b0, pinSync[3], spreadTypeReg, spreadTableReg, pinSync[2:0]};
            end
            OFS_CLK: value = {driveReg, runReg};
            OFS_DIV: value = {1'b0, divReg};
            default: value = 8'h00;
        endcase
        return value;
    endfunction : read_byte

    // A plain assign would not wake on register changes read inside the function.
    always_comb
    begin
        rdByte   = read_byte(pointer);
        nextByte = read_byte(pointer + 8'h01);
    end

    // ------------------------------------------------------------------
    // Serial slave.
    // ------------------------------------------------------------------
    // Only the low level is ever driven; the pull-up supplies the high level.
    assign sdaOut    = 1'b0;
    assign sdaOutEnN = ~sdaLow;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state     <= ST_IDLE;
            bitCnt    <= 4'h0;
            shiftReg  <= 8'h00;
            pointer   <= OFS_FREQ;
            masterAck <= 1'b0;
            sdaLow    <= 1'b0;
            regWrite  <= 1'b0;
            wrData    <= 8'h00;
        end
        else
        begin
            regWrite <= 1'b0;
            if (startSeen)
            begin
                state  <= ST_ADDR;
                bitCnt <= 4'h0;
                sdaLow <= 1'b0;
            end
            else if (stopSeen)
            begin
                state  <= ST_IDLE;
                sdaLow <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sdaLow <= 1'b0;
                    end
                    ST_ADDR, ST_CMD, ST_WDATA:
                    begin
                        if (sclRise && bitCnt != BITS_PER_BYTE)
                        begin
                            shiftReg <= {shiftReg[6:0], sdaBit};
                            bitCnt   <= bitCnt + 4'h1;
                        end
                        else if (sclFall && bitCnt == BITS_PER_BYTE)
                        begin
                            bitCnt <= 4'h0;
                            if (state == ST_ADDR)
                            begin
                                if (shiftReg[7:1] == DEV_ADDR)
                                begin
                                    masterAck <= shiftReg[0];
                                    sdaLow    <= 1'b1;
                                    state     <= ST_ADDR_ACK;
                                end
                                else
                                begin
                                    state <= ST_IDLE;
                                end
                            end
                            else if (state == ST_CMD)
                            begin
                                pointer <= shiftReg;
                                sdaLow  <= 1'b1;
                                state   <= ST_CMD_ACK;
                            end
                            else
                            begin
                                wrData   <= shiftReg;
                                regWrite <= 1'b1;
                                sdaLow   <= 1'b1;
                                state    <= ST_WDATA_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        if (sclFall)
                        begin
                            if (masterAck)
                            begin
                                shiftReg <= rdByte;
                                sdaLow   <= ~rdByte[7];
                                state    <= ST_RDATA;
                            end
                            else
                            begin
                                sdaLow <= 1'b0;
                                state  <= ST_CMD;
                            end
                        end
                    end
                    ST_CMD_ACK, ST_WDATA_ACK:
                    begin
                        if (sclFall)
                        begin
                            sdaLow <= 1'b0;
                            state  <= ST_WDATA;
                            // Further bytes of a burst land at the following offsets.
                            if (state == ST_WDATA_ACK)
                                pointer <= pointer + 8'h01;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (sclRise)
                        begin
                            bitCnt <= bitCnt + 4'h1;
                        end
                        else if (sclFall)
                        begin
                            if (bitCnt == BITS_PER_BYTE)
                            begin
                                sdaLow <= 1'b0;
                                bitCnt <= 4'h0;
                                state  <= ST_RDATA_ACK;
                            end
                            else
                            begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                sdaLow   <= ~shiftReg[6];
                            end
                        end
                    end
                    ST_RDATA_ACK:
                    begin
                        if (sclRise)
                        begin
                            masterAck <= ~sdaBit;
                        end
                        else if (sclFall)
                        begin
                            if (masterAck)
                            begin
                                shiftReg <= nextByte;
                                sdaLow   <= ~nextByte[7];
                                pointer  <= pointer + 8'h01;
                                state    <= ST_RDATA;
                            end
                            else
                            begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state  <= ST_IDLE;
                        sdaLow <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    sequence s_freq_write;
        regWrite && pointer == OFS_FREQ;
    endsequence

    sequence s_read_load;
        (state != ST_RDATA) ##1 (state == ST_RDATA);
    endsequence

    property p_sw_reset;
        @(posedge ref_clk) reset |=> !swSelect && freqSelValid == 1'b0;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("Software select not clear after reset.");

    property p_sw_path;
        @(posedge ref_clk) disable iff (reset)
        swSelect |=> freqSelect == $past(fsCode) && spreadEnable == $past(spreadEnReg);
    endproperty
    a_sw_path: assert property (p_sw_path) else $error("Register selection not in force.");

    property p_hw_path;
        @(posedge ref_clk) disable iff (reset)
        !swSelect |=> freqSelect == $past(pinSync[2:0]) && spreadEnable == $past(pinSync[3]);
    endproperty
    a_hw_path: assert property (p_hw_path) else $error("Pin selection not in force.");

    property p_undecoded;
        @(posedge ref_clk) disable iff (reset)
        swSelect && fsCode == FS_UNDECODED |=> !freqSelValid;
    endproperty
    a_undecoded: assert property (p_undecoded) else $error("All-ones code was decoded.");

    property p_capture;
        @(posedge ref_clk) disable iff (reset)
        capture && !regWrite |=> spreadEnReg == $past(pinSync[3]) && fsCode == $past(pinSync[2:0]);
    endproperty
    a_capture: assert property (p_capture) else $error("Startup pin capture missed.");

    property p_run_write;
        @(posedge ref_clk) disable iff (reset)
        regWrite && pointer == OFS_CLK |=> outRun == $past(wrData[3:0]) && outDrive == $past(wrData[7:4]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("Clock register write not applied.");

    property p_freq_write;
        @(posedge ref_clk) disable iff (reset)
        s_freq_write |=> swSelect == $past(wrData[7]) ##1 spreadType == $past(wrData[5], 2);
    endproperty
    a_freq_write: assert property (p_freq_write) else $error("Frequency register write not applied.");

    property p_readback;
        @(posedge ref_clk) disable iff (reset)
        s_read_load ##0 (pointer == OFS_FREQ && !swSelect && $stable(pinSync))
        |-> shiftReg[2:0] == pinSync[2:0] && !shiftReg[7];
    endproperty
    a_readback: assert property (p_readback) else $error("Readback ignores pin values.");

    property p_div_reserved;
        @(posedge ref_clk) disable iff (reset)
        s_read_load ##0 (pointer == OFS_DIV) |-> !shiftReg[7];
    endproperty
    a_div_reserved: assert property (p_div_reserved) else $error("Reserved divider bit read as one.");

    property p_drive_only;
        @(posedge ref_clk) disable iff (reset)
        !sdaOutEnN |-> state inside {ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK, ST_RDATA};
    endproperty
    a_drive_only: assert property (p_drive_only) else $error("Data line driven outside ack or data.");

    property p_fine;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> freqFromDivider == $past(fineFreqEnable) && feedbackValue == $past(divReg);
    endproperty
    a_fine: assert property (p_fine) else $error("Fine frequency source not followed.");

endmodule : csc_regs

//--- csc_host.sv
// Two-wire host model that drives the serial port of the register bank.
// Assumes a pull-up on both lines and an active low device data enable.
`timescale 1ns/10ps
module csc_host
    import csc_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Lines
    input  wire logic devEnN,
    input  wire logic devOut,
    output logic      sclIn,
    output logic      sdaIn
);
    logic hostLow = 1'b0;
    initial sclIn = 1'b1;
    // The pull-up wins unless a party pulls low, so no stale level is seen.
    assign sdaIn = ~hostLow & (devEnN | devOut);
    task automatic hp();
        repeat (10) @(posedge ref_clk);
    endtask : hp
    task automatic tx(input logic b);
        hostLow <= ~b;
        hp();
        sclIn <= 1'b1;
        hp();
        sclIn <= 1'b0;
        hp();
    endtask : tx
    task automatic rx(output logic b);
        hostLow <= 1'b0;
        hp();
        sclIn <= 1'b1;
        hp();
        b = sdaIn;
        sclIn <= 1'b0;
        hp();
    endtask : rx
    task automatic start();
        hostLow <= 1'b0;
        hp();
        sclIn <= 1'b1;
        hp();
        hostLow <= 1'b1;
        hp();
        sclIn <= 1'b0;
        hp();
    endtask : start
    task automatic stop();
        hostLow <= 1'b1;
        hp();
        sclIn <= 1'b1;
        hp();
        hostLow <= 1'b0;
        hp();
    endtask : stop
    task automatic txb(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) tx(d[i]);
        rx(b);
        ack = ~b;
    endtask : txb
    task automatic wr(input logic [7:0] a, input logic [7:0] o, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        txb(a, k0);
        txb(o, k1);
        txb(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : wr
    task automatic rd(input logic [7:0] o, output logic [7:0] d);
        logic k;
        start();
        txb({DEV_ADDR, 1'b0}, k);
        txb(o, k);
        start();
        txb({DEV_ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) rx(d[i]);
        tx(1'b1);
        stop();
    endtask : rd
endmodule : csc_host

//--- test_clock_synth_config_regs.sv
// Self-checking bench of the configuration register bank.
// Assumes the host model carries all serial traffic; seeded random data.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_clock_synth_config_regs
    import csc_pkg::*;
;
    logic       ref_clk = 1'b0, reset = 1'b1, sclIn, sdaIn, sdaOut, sdaOutEnN, ok;
    logic [2:0] freqSelPin = 3'h0, freqSelect;
    logic       spreadEnPin = 1'b0, fineFreqEnable = 1'b0, freqSelValid, spreadEnable;
    logic       spreadType, freqFromDivider;
    logic [1:0] spreadTable;
    logic [3:0] outDrive, outRun;
    logic [6:0] feedbackValue;
    logic [7:0] d, v, o, mdl [3];
    logic [7:0] corner [3] = '{8'h87, 8'h00, 8'hFF};
    int         cmp_count = 0, bad_count = 0;
    always #5 ref_clk = ~ref_clk;
    csc_regs i_csc_regs (.ref_clk, .reset, .sclIn, .sdaIn, .sdaOut, .sdaOutEnN,
        .freqSelPin, .spreadEnPin, .fineFreqEnable, .freqSelect, .freqSelValid,
        .spreadEnable, .spreadType, .spreadTable, .freqFromDivider, .outDrive,
        .outRun, .feedbackValue);
    csc_host i_csc_host (.ref_clk, .devEnN(sdaOutEnN), .devOut(sdaOut), .sclIn, .sdaIn);
    function automatic logic [7:0] exp_rb(input logic [7:0] a);
        if (a == OFS_FREQ)
            return mdl[0][7] ? mdl[0] : {1'b0, spreadEnPin, mdl[0][5:3], freqSelPin};
        return (a <= OFS_DIV) ? mdl[a] : 8'h00;
    endfunction : exp_rb
    task automatic check_out();
        `CHK(freqSelect, mdl[0][7] ? mdl[0][2:0] : freqSelPin)
        `CHK(spreadEnable, mdl[0][7] ? mdl[0][6] : spreadEnPin)
        `CHK(({spreadType, spreadTable}), mdl[0][5:3])
        `CHK(freqSelValid, !(mdl[0][7] && mdl[0][2:0] == FS_UNDECODED))
        `CHK(({outDrive, outRun}), mdl[1])
        `CHK(feedbackValue, mdl[2][6:0])
        `CHK(sdaOut, 1'b0)
        `CHK(freqFromDivider, fineFreqEnable)
    endtask : check_out
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        void'($urandom(32'hC1EF2D36));
        freqSelPin  <= 3'($urandom);
        spreadEnPin <= 1'($urandom);
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        mdl = '{{1'b0, spreadEnPin, 3'h0, freqSelPin}, 8'hFF, 8'h00};
        check_out();
        for (int r = 0; r < 3; r++)
        begin
            i_csc_host.rd(8'(r), d);
            `CHK(d, exp_rb(8'(r)))
        end
        $display("reset values done");
        for (int n = 0; n < 12; n++)
        begin
            o = (n < 3) ? 8'(n) : 8'($urandom % 3);
            v = (n < 3) ? corner[n] : 8'($urandom);
            freqSelPin     <= 3'($urandom);
            spreadEnPin    <= 1'($urandom);
            fineFreqEnable <= 1'($urandom);
            i_csc_host.wr({DEV_ADDR, 1'b0}, o, v, ok);
            `CHK(ok, 1'b1)
            mdl[o] = (o == OFS_DIV) ? {1'b0, v[6:0]} : v;
            check_out();
            i_csc_host.rd(o, d);
            `CHK(d, exp_rb(o))
        end
        $display("register sweep done");
        i_csc_host.wr(8'h56, OFS_CLK, 8'h5A, ok);
        `CHK(ok, 1'b0)
        i_csc_host.wr({DEV_ADDR, 1'b0}, 8'h03, 8'h5A, ok);
        i_csc_host.rd(8'h03, d);
        `CHK(d, 8'h00)
        check_out();
        $display("refusals done");
        end_of_test();
    end
    initial
    begin
        #1000000;
        bad_count++;
        end_of_test();
    end
endmodule : test_clock_synth_config_regs
